// file: verilog/tcc_timer.sv
// Operation
// R1 - capture mode: flag set on selected active pin edge
// R2 - compare mode: flag set when counter equals channel value
// R3 - flag clear: read control with flag set, then write zero
// R4 - event between read and zero write keeps flag set
// R5 - writing one to flag does nothing
// R6 - irq forwarded only while enable set; reset clears enable
// R7 - buffered bit on 0,2,4 only; disables next odd channel
// R8 - edge field nonzero, unbuffered: mode A 0 capture, 1 compare
// R9 - edge field 00: port control, mode A 1 presets low, 0 high
// R10 - capture edges: 01 rising, 10 falling, 11 both
// R11 - compare action: 01 toggle, 10 low, 11 high
// R12 - edge 00 releases pin; drive only in an active mode
// R13 - toggle on wrap for compare channels, ignored in capture
// R14 - wrap action beats compare action when coincident
// R15 - full duty forces 100%, effective from next period
// R16 - value regs hold capture or compare value, reset undefined
// R17 - capture: high byte read blocks captures until low read
// R18 - compare: high byte write blocks matches until low write
// R19 - software halts and clears counter before mode changes
// R20 - pin held stable two clocks before capture enabled
// R21 - reset clears all channel control bits
// R22 - buffered: even/odd values alternate as compare each period
//
// Decided for this implementation: the APB register port and the address map.
module tcc_timer (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // shared module counter
  input wire logic [15:0] COUNT,
  input wire logic COUNT_WRAP,
  // channel pins
  input wire logic [5:0] CHANNEL_PIN_IN,
  output logic [5:0] CHANNEL_PIN_OUT,
  output logic [5:0] CHANNEL_PIN_OE,
  // interrupt requests
  output logic [5:0] CHANNEL_IRQ
);
  localparam int N = tcc_pkg::NCH;
  localparam int W = tcc_pkg::CW;

  tcc_pkg::tcc_ctrl_s ctrl [N];
  tcc_pkg::tcc_ctrl_s next_ctrl [N];
  logic [W-1:0] value [N];
  logic [W-1:0] next_value [N];
  logic [7:0] hold_lo [N];
  logic [7:0] next_hold_lo [N];
  logic [N-1:0] out_lvl, next_out_lvl;
  logic [N-1:0] armed, next_armed;
  logic [N-1:0] cap_lock, next_cap_lock;
  logic [N-1:0] cmp_lock, next_cmp_lock;
  logic [N-1:0] max_eff, next_max_eff;
  logic [N-1:0] odd_act, next_odd_act;
  logic [31:0] rdata, next_rdata;
  logic [N-1:0] rise, fall;
  tcc_pkg::tcc_tick_s tick;

  logic acc, wr, rd;
  logic [2:0] ch_idx;
  logic [3:0] reg_ofs;
  logic hit_ch, hit_cnt;

  assign tick.count = COUNT;
  assign tick.wrap = COUNT_WRAP;

  assign acc = PSEL & PENABLE;
  assign wr = acc & PWRITE;
  // reads are served in setup so that the data stands in the access phase
  assign rd = PSEL & ~PENABLE & ~PWRITE;
  assign ch_idx = PADDR[6:4];
  assign reg_ofs = PADDR[3:0];
  assign hit_ch = (PADDR[11:7] == 5'h00) && (ch_idx < 3'(N)) &&
                  (reg_ofs == tcc_pkg::OFS_CTRL ||
                   reg_ofs == tcc_pkg::OFS_VHI ||
                   reg_ofs == tcc_pkg::OFS_VLO);
  assign hit_cnt = (PADDR == tcc_pkg::OFS_COUNTER);

  // zero wait states; unmapped access answers with an error
  assign PREADY = 1'b1;
  assign PSLVERR = acc & ~(hit_ch | hit_cnt);
  assign PRDATA = rdata;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_edge
      tcc_edge u_edge (
        .MCLK(MCLK),
        .RST_N(RST_N),
        .pin(CHANNEL_PIN_IN[g]),
        .rise(rise[g]),
        .fall(fall[g]),
        .level()
      );
    end
  endgenerate

  // per-channel mode decode
  logic [N-1:0] disabled, buffered, capture, compare, active;
  logic [N-1:0] flag_read;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      // odd channel shut off by its even partner
      disabled[i] = (i % 2 == 1) && ctrl[i-(i%2)].msb; // R7
      buffered[i] = (i % 2 == 0) && ctrl[i].msb;
      active[i] = !disabled[i] && ctrl[i].els != tcc_pkg::ELS_OFF; // R12
      capture[i] = active[i] && !buffered[i] && !ctrl[i].msa; // R8
      compare[i] = active[i] && (buffered[i] || ctrl[i].msa); // R8
    end
  end

  // flag-read arm remembers the first half of the clear sequence
  logic [N-1:0] event_now;
  logic [N-1:0] match_now;
  logic [W-1:0] cmp_val [N];
  always_comb begin
    for (int i = 0; i < N; i++) begin
      flag_read[i] = rd && hit_ch && ch_idx == 3'(i) &&
                     reg_ofs == tcc_pkg::OFS_CTRL && ctrl[i].flag;
      // buffered pairs alternate the active compare source
      if (buffered[i] && odd_act[i])
        cmp_val[i] = value[(i + 1) % N]; // R22
      else
        cmp_val[i] = value[i];
      match_now[i] = compare[i] && !cmp_lock[i] &&
                     tick.count == cmp_val[i]; // R2 R18
      event_now[i] = match_now[i] ||
                     (capture[i] && !cap_lock[i] &&
                      ((ctrl[i].els[0] && rise[i]) ||
                       (ctrl[i].els[1] && fall[i]))); // R1 R10 R17
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      next_ctrl[i] = ctrl[i];
      next_value[i] = value[i];
      next_hold_lo[i] = hold_lo[i];
    end
    next_out_lvl = out_lvl;
    next_armed = armed;
    next_cap_lock = cap_lock;
    next_cmp_lock = cmp_lock;
    next_max_eff = max_eff;
    next_odd_act = odd_act;
    next_rdata = 32'h0000_0000;

    for (int i = 0; i < N; i++) begin
      if (flag_read[i])
        next_armed[i] = 1'b1;
      // software access
      if ((rd || wr) && hit_ch && ch_idx == 3'(i)) begin
        unique case (reg_ofs)
          tcc_pkg::OFS_CTRL: begin
            if (rd) begin
              next_rdata = {24'h000000, ctrl[i]};
              if (disabled[i])
                next_rdata = 32'h0000_0000; // R7
            end else if (!disabled[i]) begin
              next_ctrl[i].ie = PWDATA[tcc_pkg::B_IE]; // R6
              next_ctrl[i].msb = (i % 2 == 0) &&
                                 PWDATA[tcc_pkg::B_MSB]; // R7
              next_ctrl[i].msa = PWDATA[tcc_pkg::B_MSA];
              next_ctrl[i].els = PWDATA[tcc_pkg::B_ELSH:tcc_pkg::B_ELSL];
              next_ctrl[i].tov = PWDATA[tcc_pkg::B_TOV];
              next_ctrl[i].max = PWDATA[tcc_pkg::B_MAX];
              // zero write after arming clears; one write ignored
              if (!PWDATA[tcc_pkg::B_FLAG] && armed[i])
                next_ctrl[i].flag = 1'b0; // R3 R5
              next_armed[i] = 1'b0;
              // preset level while the pin is released
              if (PWDATA[tcc_pkg::B_ELSH:tcc_pkg::B_ELSL] ==
                  tcc_pkg::ELS_OFF)
                next_out_lvl[i] = ~PWDATA[tcc_pkg::B_MSA]; // R9
            end
          end
          tcc_pkg::OFS_VHI: begin
            if (rd) begin
              next_rdata = {24'h000000, value[i][15:8]};
              if (capture[i]) begin
                next_cap_lock[i] = 1'b1; // R17
                next_hold_lo[i] = value[i][7:0];
              end
            end else begin
              next_value[i][15:8] = PWDATA[7:0]; // R16
              next_cmp_lock[i] = 1'b1; // R18
            end
          end
          tcc_pkg::OFS_VLO: begin
            if (rd) begin
              next_rdata = {24'h000000, value[i][7:0]};
              next_cap_lock[i] = 1'b0; // R17
            end else begin
              next_value[i][7:0] = PWDATA[7:0];
              next_cmp_lock[i] = 1'b0; // R18
            end
          end
          default: ;
        endcase
      end

      // capture latches the counter
      if (capture[i] && !cap_lock[i] && event_now[i])
        next_value[i] = tick.count; // R16

      // set wins over a simultaneous clear
      if (event_now[i]) begin
        next_ctrl[i].flag = 1'b1; // R1 R2 R4
        next_armed[i] = 1'b0; // R4
      end

      // output action; wrap takes precedence
      if (compare[i]) begin
        if (tick.wrap && ctrl[i].tov) begin
          next_out_lvl[i] = ~out_lvl[i]; // R13 R14
          next_max_eff[i] = ctrl[i].max; // R15
          if (ctrl[i].max)
            next_out_lvl[i] = 1'b1; // R15
        end else if (match_now[i] && !(max_eff[i] && ctrl[i].tov)) begin
          unique case (ctrl[i].els)
            tcc_pkg::ELS_RISE: next_out_lvl[i] = ~out_lvl[i]; // R11
            tcc_pkg::ELS_FALL: next_out_lvl[i] = 1'b0; // R11
            tcc_pkg::ELS_BOTH: next_out_lvl[i] = 1'b1; // R11
            default: ;
          endcase
        end
      end
      // every wrap opens a period, whatever the output does then
      if (compare[i] && buffered[i] && tick.wrap)
        next_odd_act[i] = ~odd_act[i]; // R22
      if (!buffered[i])
        next_odd_act[i] = 1'b0;
    end

    // counter readback for software convenience
    if (rd && hit_cnt)
      next_rdata = {16'h0000, tick.count};
    // hold_lo keeps the low byte coherent with the earlier high read
    if (rd && hit_ch && reg_ofs == tcc_pkg::OFS_VLO &&
        cap_lock[ch_idx])
      next_rdata = {24'h000000, hold_lo[ch_idx]}; // R17
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < N; i++)
        ctrl[i] <= tcc_pkg::CTRL_RST; // R21
      out_lvl <= '1;
      armed <= '0;
      cap_lock <= '0;
      cmp_lock <= '0;
      max_eff <= '0;
      odd_act <= '0;
      rdata <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < N; i++)
        ctrl[i] <= next_ctrl[i];
      out_lvl <= next_out_lvl;
      armed <= next_armed;
      cap_lock <= next_cap_lock;
      cmp_lock <= next_cmp_lock;
      max_eff <= next_max_eff;
      odd_act <= next_odd_act;
      rdata <= next_rdata;
    end
  end

  // value registers carry no reset
  always_ff @(posedge MCLK) begin
    for (int i = 0; i < N; i++) begin
      value[i] <= next_value[i];
      hold_lo[i] <= next_hold_lo[i];
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      CHANNEL_IRQ[i] = ctrl[i].flag && ctrl[i].ie && !disabled[i]; // R6
      CHANNEL_PIN_OE[i] = compare[i]; // R12
      CHANNEL_PIN_OUT[i] = out_lvl[i] && compare[i];
    end
  end
endmodule : tcc_timer

// file: verilog/tcc_pkg.sv
package tcc_pkg;
  localparam int NCH = 6;
  localparam int CW = 16;
  // register map: one word per register, 3 words per channel, stride 0x10
  localparam logic [11:0] CH_STRIDE = 12'h010;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_VHI = 4'h4;
  localparam logic [3:0] OFS_VLO = 4'h8;
  localparam logic [11:0] OFS_COUNTER = 12'h060;
  // control bit positions
  localparam int B_FLAG = 7;
  localparam int B_IE = 6;
  localparam int B_MSB = 5;
  localparam int B_MSA = 4;
  localparam int B_ELSH = 3;
  localparam int B_ELSL = 2;
  localparam int B_TOV = 1;
  localparam int B_MAX = 0;
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_RISE = 2'h1;
  localparam logic [1:0] ELS_FALL = 2'h2;
  localparam logic [1:0] ELS_BOTH = 2'h3;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [CW-1:0] CNT_MAX = 16'hffff;

  typedef struct packed {
    logic flag;
    logic ie;
    logic msb;
    logic msa;
    logic [1:0] els;
    logic tov;
    logic max;
  } tcc_ctrl_s;

  // per-channel timing inputs from the shared counter
  typedef struct packed {
    logic [CW-1:0] count;
    logic wrap;
  } tcc_tick_s;
endpackage : tcc_pkg

// file: verilog/tcc_edge.sv
// two-stage synchroniser plus edge detect for one capture pin
module tcc_edge (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // pin
  input wire logic pin,
  // edges and synchronised level
  output logic rise,
  output logic fall,
  output logic level
);
  logic s1, s2, s3;
  logic next_s1, next_s2, next_s3;

  always_comb begin
    next_s1 = pin;
    next_s2 = s1;
    next_s3 = s2;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
    end
  end

  // s1 is only read by s2
  assign rise = s2 & ~s3;
  assign fall = ~s2 & s3;
  assign level = s2;
endmodule : tcc_edge

// file: verification/tcc_timer_properties.sv
module tcc_timer_properties (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // counter
  input wire logic [15:0] COUNT,
  input wire logic COUNT_WRAP,
  // pins and requests
  input wire logic [5:0] CHANNEL_PIN_IN,
  input wire logic [5:0] CHANNEL_PIN_OUT,
  input wire logic [5:0] CHANNEL_PIN_OE,
  input wire logic [5:0] CHANNEL_IRQ
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);
  logic wr0;
  logic [7:0] d;
  // only channel 0 control writes are watched
  assign wr0 = PSEL && PENABLE && PWRITE && PADDR == 12'h000;
  assign d = PWDATA[7:0];
  property p_ready;
    PSEL && PENABLE |-> PREADY;
  endproperty
  a_ready: assert property (p_ready) else $error("ready low");
  property p_err;
    PSLVERR |-> PSEL && PENABLE;
  endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_rst;
    $rose(RST_N) |-> CHANNEL_IRQ == 6'h00 && CHANNEL_PIN_OE == 6'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_ie_off;
    wr0 && !d[6] |=> !CHANNEL_IRQ[0];
  endproperty
  a_ie_off: assert property (p_ie_off) else $error("irq masked");
  property p_pin_off;
    wr0 && d[3:2] == 2'h0 |=> (!CHANNEL_PIN_OE[0]) [*2];
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin kept");
  property p_cap;
    wr0 && d[5:4] == 2'h0 |=> !CHANNEL_PIN_OE[0];
  endproperty
  a_cap: assert property (p_cap) else $error("capture drives");
  property p_cmp;
    wr0 && d[4] && d[3:2] != 2'h0 |=> CHANNEL_PIN_OE[0];
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare idle");
  property p_buf;
    wr0 && d[5] |=> (!CHANNEL_PIN_OE[1]) [*3];
  endproperty
  a_buf: assert property (p_buf) else $error("odd pin kept");
  c_irq: cover property (wr0 ##1 CHANNEL_IRQ[0]);
  c_err: cover property (PSLVERR);
  c_wrap: cover property (COUNT_WRAP && CHANNEL_PIN_OE[0]);
endmodule : tcc_timer_properties

bind tcc_timer tcc_timer_properties u_props (.*);

// file: verification/tcc_pin_model.sv
module tcc_pin_model (
  // outside source
  input wire logic [5:0] ext_level,
  // device side
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  output logic [5:0] pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // a driven pin shows the channel, the source lets go there
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : tcc_pin_model

// file: verification/tcc_timer_tb_top.sv
module tcc_timer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, rst_n, psel, penable, pwrite, wrap, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] count;
  logic [5:0] ext, pin_in, pin_out, pin_oe, irq;
  logic [7:0] q;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  tcc_timer dut (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .COUNT(count),
    .COUNT_WRAP(wrap), .CHANNEL_PIN_IN(pin_in), .CHANNEL_PIN_OUT(pin_out),
    .CHANNEL_PIN_OE(pin_oe), .CHANNEL_IRQ(irq));
  tcc_pin_model pins (.ext_level(ext), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_in(pin_in));
  initial begin
    mclk = 0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, s);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick
  // read data stands in the access phase and is taken at its last edge
  task automatic apb(input logic w, input logic [11:0] a, logic [7:0] v);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    err = pslverr;
    q = prdata[7:0];
    psel <= 0;
    penable <= 0;
    @(negedge mclk);
  endtask : apb
  task automatic clr(input logic [7:0] v);
    apb(0, 0, 0);
    apb(1, 0, v);
    chk("clear", 8'h00, {7'h0, irq[0]});
  endtask : clr
  task automatic pin(input logic l);
    @(posedge mclk);
    ext[0] <= l;
    tick(6);
  endtask : pin
  task automatic hit(input logic [15:0] c, input logic w);
    @(posedge mclk);
    count <= c;
    wrap <= w;
    @(posedge mclk);
    count <= 0;
    wrap <= 0;
    tick(3);
  endtask : hit
  task automatic t_reset;
    for (int c = 0; c < 6; c++) begin
      apb(0, 12'(c * 16), 0);
      chk("ctrl", tcc_pkg::CTRL_RST, q);
    end
    chk("irq oe", 8'h00, {2'h0, irq | pin_oe});
    apb(0, 12'h0fc, 0);
    chk("slverr", 8'h01, {7'h0, err});
  endtask : t_reset
  task automatic t_capture;
    logic [7:0] v;
    for (int i = 1; i < 4; i++) begin
      v = 8'h40 | 8'(i << 2);
      apb(1, 0, v | 8'h80);
      chk("flag one", 8'h00, {7'h0, irq[0]});
      pin(1);
      chk("rise", {7'h0, v[2]}, {7'h0, irq[0]});
      clr(v);
      pin(0);
      chk("fall", {7'h0, v[3]}, {7'h0, irq[0]});
      clr(v);
    end
    @(posedge mclk);
    count <= 16'h1234;
    pin(1);
    apb(0, 0, 0);
    pin(0);
    apb(1, 0, v);
    chk("keep", 8'h01, {7'h0, irq[0]});
    clr(v);
    @(posedge mclk);
    count <= 16'h5678;
    apb(0, 12'h004, 0);
    chk("cap hi", 8'h12, q);
    pin(1);
    chk("blocked", 8'h00, {7'h0, irq[0]});
    apb(0, 12'h008, 0);
    chk("cap lo", 8'h34, q);
    clr(v);
  endtask : t_capture
  task automatic t_compare;
    logic [7:0] v;
    logic o;
    apb(1, 12'h004, 0);
    apb(1, 12'h008, 8'h40);
    for (int i = 1; i < 4; i++) begin
      v = 8'h50 | 8'(i << 2);
      apb(1, 0, v);
      chk("drive", 8'h01, {7'h0, pin_oe[0]});
      o = (i == 1) ? ~pin_out[0] : v[2];
      hit(16'h0040, 0);
      chk("match", 8'h01, {7'h0, irq[0]});
      chk("level", {7'h0, o}, {7'h0, pin_out[0]});
      clr(v);
    end
    apb(1, 12'h004, 0);
    hit(16'h0040, 0);
    chk("held", 8'h00, {7'h0, irq[0]});
    apb(1, 12'h008, 8'h40);
    hit(16'h0040, 0);
    chk("armed", 8'h01, {7'h0, irq[0]});
    clr(v);
  endtask : t_compare
  // output is high here: the last compare action set it
  task automatic t_wrap;
    apb(1, 0, 8'h1e);
    hit(16'h0040, 1);
    chk("wrap wins", 8'h00, {7'h0, pin_out[0]});
    hit(16'h0000, 1);
    chk("wrap", 8'h01, {7'h0, pin_out[0]});
    apb(1, 0, 8'h1b);
    hit(16'h0040, 0);
    chk("max late", 8'h00, {7'h0, pin_out[0]});
    hit(16'h0000, 1);
    hit(16'h0040, 0);
    chk("max on", 8'h01, {7'h0, pin_out[0]});
    apb(1, 0, 8'h1a);
    hit(16'h0040, 0);
    chk("max held", 8'h01, {7'h0, pin_out[0]});
  endtask : t_wrap
  task automatic t_buffer;
    apb(1, 12'h014, 0);
    apb(1, 12'h018, 8'h50);
    clr(8'h6c);
    apb(1, 12'h010, 8'h5c);
    apb(0, 12'h010, 0);
    chk("odd ctrl", 8'h00, q);
    chk("odd pin", 8'h00, {7'h0, pin_oe[1]});
    hit(16'h0050, 0);
    chk("even src", 8'h00, {7'h0, irq[0]});
    hit(16'h0000, 1);
    hit(16'h0040, 0);
    chk("odd src", 8'h00, {7'h0, irq[0]});
    hit(16'h0050, 0);
    chk("odd hit", 8'h01, {7'h0, irq[0]});
    apb(1, 0, 8'h10);
    chk("released", 8'h00, {7'h0, pin_oe[0]});
    apb(0, 12'h010, 0);
    chk("odd kept", 8'h00, q);
    apb(1, 0, 8'h1c);
    chk("preset lo", 8'h00, {7'h0, pin_out[0]});
    apb(1, 0, 0);
    apb(1, 0, 8'h1c);
    chk("preset hi", 8'h01, {7'h0, pin_out[0]});
  endtask : t_buffer
  initial begin
    {rst_n, psel, penable, pwrite, wrap} = 0;
    {paddr, pwdata, count, ext} = 0;
    repeat (10) @(posedge mclk);
    rst_n <= 1;
    t_reset();
    t_capture();
    t_compare();
    t_wrap();
    t_buffer();
    // second reset in mid-run, with channel 0 still driving
    @(posedge mclk);
    rst_n <= 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1;
    t_reset();
    tally_and_finish();
  end
endmodule : tcc_timer_tb_top
